// File: shared/vxfg_pkg.sv
package vxfg_pkg;

    // register byte addresses on the apb port
    localparam logic [7:0] ADDR_BASE = 8'h00;
    localparam logic [7:0] ADDR_EXT = 8'h04;
    localparam logic [7:0] ADDR_ID = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;

    // base control word fields
    localparam int MP_BIT = 1;
    localparam int EM_BIT = 2;
    localparam int TS_BIT = 3;
    localparam int NE_BIT = 5;
    localparam int AM_BIT = 18;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic [31:0] BASE_WMASK = 32'h0004_002e;

    // extended control word fields
    localparam int OSFS_BIT = 9;
    localparam int OSVF_BIT = 10;
    localparam logic [31:0] EXT_RST = 32'h0000_0000;
    localparam logic [31:0] EXT_WMASK = 32'h0000_0600;

    // identification result (leaf 1) and program status word fields
    localparam int ID_LF_BIT = 19;
    localparam int ID_FS_BIT = 24;
    localparam int ID_V1_BIT = 25;
    localparam int ID_V2_BIT = 26;
    localparam int PSW_AC_BIT = 18;
    localparam logic [1:0] CPL_USER = 2'h3;

    // sticky event status bits, same layout in the mask register
    localparam int STAT_W = 6;
    localparam int ST_UD = 0;
    localparam int ST_NM = 1;
    localparam int ST_GP = 2;
    localparam int ST_AC = 3;
    localparam int ST_XF = 4;
    localparam int ST_CFG = 5;
    localparam logic [STAT_W-1:0] STAT_RST = 6'h00;
    localparam logic [STAT_W-1:0] MASK_RST = 6'h00;

    // a verdict appears this many cycles after its request
    localparam int VERDICT_LAT = 1;

    typedef enum logic [2:0] {
        OP_FLOAT = 3'h0, OP_PACKED_INT = 3'h1, OP_HINT = 3'h2, OP_NT_INT_STORE = 3'h3,
        OP_LINE_FLUSH = 3'h4, OP_UNALIGNED_MOVE = 3'h5, OP_FULL_STATE = 3'h6
    } vxfg_op_t;

    typedef enum logic [1:0] {SZ_16 = 2'h0, SZ_32 = 2'h1, SZ_64 = 2'h2, SZ_128 = 2'h3} vxfg_size_t;

    typedef enum logic [2:0] {
        FLT_NONE = 3'h0, FLT_UD = 3'h1, FLT_NM = 3'h2, FLT_GP = 3'h3, FLT_AC = 3'h4, FLT_XF = 3'h5
    } vxfg_fault_t;

    typedef struct packed {
        logic valid;
        vxfg_op_t op;
        logic mem_ref;
        logic stack_seg;
        vxfg_size_t size;
        logic [3:0] addr_lo;
        logic [1:0] current_privilege_level;
        logic [31:0] psw;
        logic fp_unmasked;
        logic fp_masked;
    } vxfg_req_t;

    typedef struct packed {
        logic valid;
        vxfg_fault_t fault;
        logic commit;
        logic default_result;
    } vxfg_verdict_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] ext;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        vxfg_verdict_t verdict;
        logic irq;
    } vxfg_state_t;

    localparam vxfg_state_t STATE_RST = '{base: BASE_RST, ext: EXT_RST, stat: STAT_RST,
        mask: MASK_RST, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
        verdict: '{valid: 1'b0, fault: FLT_NONE, commit: 1'b0, default_result: 1'b0}, irq: 1'b0};

    // natural alignment test for an operand of the given size
    function automatic logic misaligned(input logic [3:0] addr_lo, input vxfg_size_t size);
        case (size)
            SZ_16: misaligned = addr_lo[0];
            SZ_32: misaligned = |addr_lo[1:0];
            SZ_64: misaligned = |addr_lo[2:0];
            default: misaligned = |addr_lo;
        endcase
    endfunction

endpackage

// File: hdl/vxfg_check.sv
`timescale 1ns/1ps
module vxfg_check (
    input vxfg_pkg::vxfg_req_t req,
    input wire logic [31:0] base,
    input wire logic [31:0] ext,
    input wire logic [31:0] id_word,
    output vxfg_pkg::vxfg_verdict_t verdict
);

    logic exempt_table;
    logic exempt_osfs;
    logic feat_ud;
    logic ud;
    logic nm;
    logic mis;
    logic gp;
    logic ac;

    // every gate resolves here, before the instruction may touch any state
    always_comb begin
        // pause, prefetch, fences, nt integer store and line flush sit outside the table
        exempt_table = req.op inside {vxfg_pkg::OP_HINT, vxfg_pkg::OP_NT_INT_STORE, vxfg_pkg::OP_LINE_FLUSH};
        exempt_osfs = exempt_table || req.op inside {vxfg_pkg::OP_PACKED_INT, vxfg_pkg::OP_FULL_STATE};
        // line flush and full state have their own feature flags, all others need both vector flags
        if (req.op == vxfg_pkg::OP_LINE_FLUSH) begin
            feat_ud = !id_word[vxfg_pkg::ID_LF_BIT];
        end else if (req.op == vxfg_pkg::OP_FULL_STATE) begin
            feat_ud = !id_word[vxfg_pkg::ID_FS_BIT];
        end else begin
            feat_ud = !(id_word[vxfg_pkg::ID_V1_BIT] && id_word[vxfg_pkg::ID_V2_BIT]);
        end
        ud = feat_ud
            || (base[vxfg_pkg::EM_BIT] && !exempt_table)
            || (!ext[vxfg_pkg::OSFS_BIT] && !exempt_osfs);
        nm = base[vxfg_pkg::TS_BIT] && !exempt_table;
        mis = req.mem_ref && vxfg_pkg::misaligned(req.addr_lo, req.size);
        // stack segment references take the same path: protection, not stack fault
        gp = mis && req.size == vxfg_pkg::SZ_128 && !exempt_table
            && req.op != vxfg_pkg::OP_UNALIGNED_MOVE;
        // 128-bit misalignment on unaligned moves is not reported here
        ac = mis && req.size != vxfg_pkg::SZ_128 && base[vxfg_pkg::AM_BIT]
            && req.psw[vxfg_pkg::PSW_AC_BIT] && req.current_privilege_level == vxfg_pkg::CPL_USER;
        verdict.valid = req.valid;
        // numeric error flag and the ignore pin are never consulted
        if (!req.valid) begin
            verdict.fault = vxfg_pkg::FLT_NONE;
        end else if (ud) begin
            verdict.fault = vxfg_pkg::FLT_UD;
        end else if (nm) begin
            verdict.fault = vxfg_pkg::FLT_NM;
        end else if (gp) begin
            verdict.fault = vxfg_pkg::FLT_GP;
        end else if (ac) begin
            verdict.fault = vxfg_pkg::FLT_AC;
        end else if (req.fp_unmasked) begin
            verdict.fault = ext[vxfg_pkg::OSVF_BIT] ? vxfg_pkg::FLT_XF : vxfg_pkg::FLT_UD;
        end else begin
            verdict.fault = vxfg_pkg::FLT_NONE;
        end
        verdict.commit = req.valid && verdict.fault == vxfg_pkg::FLT_NONE;
        verdict.default_result = verdict.commit && req.fp_masked;
    end

endmodule // vxfg_check

// File: hdl/vxfg_fault_gate.sv
// Summary of operation
// - identification bit 24 reports full save support
// - setting full-save enable without support faults
// - full-save enable clear gives invalid opcode
// - all enables good: execute, unmasked gives vector fault
// - unmasked exception, vector-fault enable clear: invalid opcode
// - vector feature flags 25/26 zero: invalid opcode
// - line flush needs line-flush flag bit 19
// - software fallback flag set gives invalid opcode
// - task switched flag set gives device unavailable
// - misaligned 128-bit reference: protection fault, unaligned moves excepted
// - misaligned stack 128-bit reference: protection, not stack
// - alignment check needs mask enable, flag, privilege 3
// - unaligned moves check 16/32/64 misalignment only
// - masked exception writes default result, no fault
// - numeric error flag and ignore pin ignored
`timescale 1ns/1ps
module vxfg_fault_gate #(
    parameter bit FEAT_FULL_SAVE = 1'b1,
    parameter bit FEAT_LINE_FLUSH = 1'b1,
    parameter bit FEAT_VEC1 = 1'b1,
    parameter bit FEAT_VEC2 = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input vxfg_pkg::vxfg_req_t req,
    output vxfg_pkg::vxfg_verdict_t verdict,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state and wiring

    vxfg_pkg::vxfg_state_t st;
    vxfg_pkg::vxfg_state_t next_st;
    vxfg_pkg::vxfg_verdict_t chk;
    logic [31:0] id_word;
    logic setup;
    logic access;
    logic [vxfg_pkg::STAT_W-1:0] ev_set;
    logic [vxfg_pkg::STAT_W-1:0] rd_clr;

    // identification result is fixed by the build, read-only to software
    assign id_word = (32'(FEAT_FULL_SAVE) << vxfg_pkg::ID_FS_BIT)
        | (32'(FEAT_VEC1) << vxfg_pkg::ID_V1_BIT)
        | (32'(FEAT_VEC2) << vxfg_pkg::ID_V2_BIT)
        | (32'(FEAT_LINE_FLUSH) << vxfg_pkg::ID_LF_BIT);

    assign setup = psel && !penable;
    assign access = psel && penable && st.pready;

    // a write that would turn on full-save without the feature is refused
    function automatic logic bad_ext_write(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        bad_ext_write = wr && addr == vxfg_pkg::ADDR_EXT && data[vxfg_pkg::OSFS_BIT] && !FEAT_FULL_SAVE;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // fault decision for the instruction on the request port

    vxfg_check u_check (
        .req(req),
        .base(st.base),
        .ext(st.ext),
        .id_word(id_word),
        .verdict(chk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    // read data and error are decided in setup so both leave flip-flops in access
    always_comb begin
        next_st = st;
        ev_set = '0;
        rd_clr = '0;
        next_st.pready = 1'b0;
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.pslverr = 1'b0;
            case (paddr)
                vxfg_pkg::ADDR_BASE: begin
                    next_st.prdata = st.base;
                end
                vxfg_pkg::ADDR_EXT: begin
                    next_st.prdata = st.ext;
                    next_st.pslverr = bad_ext_write(pwrite, paddr, pwdata);
                end
                vxfg_pkg::ADDR_ID: begin
                    next_st.prdata = id_word;
                end
                vxfg_pkg::ADDR_STAT: begin
                    next_st.prdata = {26'h0, st.stat};
                end
                vxfg_pkg::ADDR_MASK: begin
                    next_st.prdata = {26'h0, st.mask};
                end
                default: begin
                    next_st.prdata = 32'h0000_0000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        // writes land only at the access edge; id and status ignore writes
        if (access && pwrite && !st.pslverr) begin
            case (paddr)
                vxfg_pkg::ADDR_BASE: begin
                    next_st.base = pwdata & vxfg_pkg::BASE_WMASK;
                end
                vxfg_pkg::ADDR_EXT: begin
                    next_st.ext = pwdata & vxfg_pkg::EXT_WMASK;
                end
                vxfg_pkg::ADDR_MASK: begin
                    next_st.mask = pwdata[vxfg_pkg::STAT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (access && pwrite && bad_ext_write(pwrite, paddr, pwdata)) begin
            ev_set[vxfg_pkg::ST_CFG] = 1'b1;
        end
        // only the bits software actually saw are cleared by the read
        if (access && !pwrite && paddr == vxfg_pkg::ADDR_STAT) begin
            rd_clr = st.prdata[vxfg_pkg::STAT_W-1:0];
        end
        ev_set[vxfg_pkg::ST_UD] = chk.fault == vxfg_pkg::FLT_UD;
        ev_set[vxfg_pkg::ST_NM] = chk.fault == vxfg_pkg::FLT_NM;
        ev_set[vxfg_pkg::ST_GP] = chk.fault == vxfg_pkg::FLT_GP;
        ev_set[vxfg_pkg::ST_AC] = chk.fault == vxfg_pkg::FLT_AC;
        ev_set[vxfg_pkg::ST_XF] = chk.fault == vxfg_pkg::FLT_XF;
        // set wins over a clear arriving in the same cycle
        next_st.stat = (st.stat & ~rd_clr) | ev_set;
        next_st.verdict = chk;
        next_st.irq = |(next_st.stat & next_st.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= vxfg_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign verdict = st.verdict;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic cfg_good;
    logic feat_good;
    assign feat_good = FEAT_VEC1 && FEAT_VEC2;
    assign cfg_good = feat_good && st.ext[vxfg_pkg::OSFS_BIT] && !st.base[vxfg_pkg::EM_BIT];

    sequence s_bad_ext_setup;
        setup && bad_ext_write(pwrite, paddr, pwdata);
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    sequence s_float_ok_ts_clear;
        req.valid && req.op == vxfg_pkg::OP_FLOAT && cfg_good && !st.base[vxfg_pkg::TS_BIT]
            && !req.mem_ref;
    endsequence

    AST_ID_FULL_SAVE: assert property (
        (setup && paddr == vxfg_pkg::ADDR_ID) |=> pready && prdata[24] == FEAT_FULL_SAVE)
        else $error("identification bit 24 wrong");

    AST_CFG_REJECT: assert property (
        s_bad_ext_setup ##1 s_access_done |-> pslverr ##1 (!st.ext[vxfg_pkg::OSFS_BIT] && st.stat[vxfg_pkg::ST_CFG]))
        else $error("full-save enable write not refused");

    AST_OSFS_UD: assert property (
        (req.valid && req.op == vxfg_pkg::OP_FLOAT && !st.ext[vxfg_pkg::OSFS_BIT])
            |=> verdict.valid && verdict.fault == vxfg_pkg::FLT_UD)
        else $error("full-save enable clear did not fault");

    AST_EXEC_XF: assert property (
        (s_float_ok_ts_clear and (req.fp_unmasked && st.ext[vxfg_pkg::OSVF_BIT]))
            |=> verdict.fault == vxfg_pkg::FLT_XF && !verdict.commit)
        else $error("unmasked exception not reported as vector fault");

    AST_XF_NEEDS_OSVF: assert property (
        (s_float_ok_ts_clear and (req.fp_unmasked && !st.ext[vxfg_pkg::OSVF_BIT]))
            |=> verdict.fault == vxfg_pkg::FLT_UD)
        else $error("vector fault raised without its enable");

    AST_EM_UD: assert property (
        (req.valid && req.op == vxfg_pkg::OP_FLOAT && st.base[vxfg_pkg::EM_BIT])
            |=> verdict.fault == vxfg_pkg::FLT_UD)
        else $error("fallback flag did not give invalid opcode");

    AST_HINT_EXEMPT: assert property (
        (req.valid && req.op == vxfg_pkg::OP_HINT && feat_good && !req.mem_ref && !req.fp_unmasked)
            |=> verdict.commit)
        else $error("hint operation was gated");

    AST_TS_NM: assert property (
        (req.valid && req.op == vxfg_pkg::OP_FLOAT && cfg_good && st.base[vxfg_pkg::TS_BIT])
            |=> verdict.fault == vxfg_pkg::FLT_NM ##1 st.stat[vxfg_pkg::ST_NM] || $past(access))
        else $error("task switched flag did not give device unavailable");

    AST_GP_ALIGN: assert property (
        (req.valid && req.op == vxfg_pkg::OP_FLOAT && cfg_good && !st.base[vxfg_pkg::TS_BIT]
            && req.mem_ref && req.size == vxfg_pkg::SZ_128 && req.addr_lo != 4'h0)
            |=> verdict.fault == vxfg_pkg::FLT_GP)
        else $error("misaligned 128-bit reference not faulted");

    AST_UMOVE_NO_GP: assert property (
        (req.valid && req.op == vxfg_pkg::OP_UNALIGNED_MOVE) |=> verdict.fault != vxfg_pkg::FLT_GP)
        else $error("unaligned move raised protection fault");

    AST_AC_GATED: assert property (
        (verdict.fault == vxfg_pkg::FLT_AC)
            |-> $past(st.base[vxfg_pkg::AM_BIT]) && $past(req.psw[vxfg_pkg::PSW_AC_BIT])
            && $past(req.current_privilege_level) == vxfg_pkg::CPL_USER)
        else $error("alignment check without all three enables");

    AST_MASKED_DEFAULT: assert property (
        (s_float_ok_ts_clear and (req.fp_masked && !req.fp_unmasked))
            |=> verdict.commit && verdict.default_result && verdict.fault == vxfg_pkg::FLT_NONE)
        else $error("masked exception did not take default result");

    AST_NO_COMMIT_ON_FAULT: assert property (
        (verdict.fault != vxfg_pkg::FLT_NONE) |-> !verdict.commit && verdict.valid)
        else $error("faulting instruction committed");

    // only reachable in a build without both vector flags
    AST_FEAT_UD: assert property (
        (req.valid && !feat_good && req.op != vxfg_pkg::OP_LINE_FLUSH) |=> verdict.fault == vxfg_pkg::FLT_UD)
        else $error("missing vector feature did not give invalid opcode");

    AST_IRQ_LEVEL: assert property (
        (verdict.fault == vxfg_pkg::FLT_UD && st.mask[vxfg_pkg::ST_UD]) |-> irq)
        else $error("unmasked event did not raise interrupt");

endmodule // vxfg_fault_gate

// File: sim/vxfg_decoder_model.sv
`timescale 1ns/1ps
// stands in for the instruction decoder: one request on each edge where go is high
module vxfg_decoder_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input vxfg_pkg::vxfg_req_t cmd,
    output vxfg_pkg::vxfg_req_t req
);
    vxfg_pkg::vxfg_req_t nxt;

    ////////////////////////////////////////////////////////////////
    // between requests the payload flips every cycle, so stale fields never look valid
    // the word is built first so the request changes by one assignment per edge
    initial req = '0;
    always @(posedge clock) begin
        if (!rst_n) begin
            req <= '0;
        end else if (go) begin
            nxt = cmd;
            nxt.valid = 1'b1;
            req <= nxt;
        end else begin
            nxt = ~req;
            nxt.valid = 1'b0;
            req <= nxt;
        end
    end
endmodule // vxfg_decoder_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic go = 1'b0;
    logic irq;
    vxfg_pkg::vxfg_req_t cmd = '0;
    vxfg_pkg::vxfg_req_t req;
    vxfg_pkg::vxfg_verdict_t verdict;
    int failures = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h5e49dc21;
    logic [31:0] sh_base = 32'h0000_0000;
    logic [31:0] sh_ext = 32'h0000_0000;
    logic [5:0] sh_mask = 6'h00;
    logic [5:0] exp_stat = 6'h00;
    logic pv = 1'b0;
    logic pm = 1'b0;
    vxfg_pkg::vxfg_fault_t pf = vxfg_pkg::FLT_NONE;
    logic [31:0] prdata2;
    logic pslverr2;
    vxfg_pkg::vxfg_verdict_t verdict2;
    logic [31:0] rd2 = 32'h0000_0000;
    logic err2 = 1'b0;
    logic [31:0] sh_ext2 = 32'h0000_0000;
    vxfg_pkg::vxfg_fault_t pf2 = vxfg_pkg::FLT_NONE;

    ////////////////////////////////////////////////////////////////
    // 50 MHz clock
    always #10 clock = ~clock;

    vxfg_fault_gate i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req(req), .verdict(verdict), .irq(irq));
    vxfg_decoder_model i_dec (.clock(clock), .rst_n(rst_n), .go(go), .cmd(cmd), .req(req));
    // lean build on the same bus and requests: no full save, second vector flag absent
    vxfg_fault_gate #(.FEAT_FULL_SAVE(1'b0), .FEAT_LINE_FLUSH(1'b1), .FEAT_VEC1(1'b1), .FEAT_VEC2(1'b0)) i_dut2 (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(), .pslverr(pslverr2),
        .req(req), .verdict(verdict2), .irq());

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // feature flags are left out here: the lean build is held against its own flags below
    function automatic vxfg_pkg::vxfg_fault_t exp_fault(input vxfg_pkg::vxfg_req_t r, input logic [31:0] b,
        input logic [31:0] e);
        logic ex;
        logic mis;
        logic [3:0] m;
        ex = r.op inside {vxfg_pkg::OP_HINT, vxfg_pkg::OP_NT_INT_STORE, vxfg_pkg::OP_LINE_FLUSH};
        m = (r.size == vxfg_pkg::SZ_16) ? 4'h1 : (r.size == vxfg_pkg::SZ_32) ? 4'h3 :
            (r.size == vxfg_pkg::SZ_64) ? 4'h7 : 4'hf;
        mis = r.mem_ref && (|(r.addr_lo & m));
        if (!ex && b[2]) return vxfg_pkg::FLT_UD;
        if (!ex && !e[9] && !(r.op inside {vxfg_pkg::OP_PACKED_INT, vxfg_pkg::OP_FULL_STATE}))
            return vxfg_pkg::FLT_UD;
        if (!ex && b[3]) return vxfg_pkg::FLT_NM;
        if (mis && r.size == vxfg_pkg::SZ_128 && !ex && r.op != vxfg_pkg::OP_UNALIGNED_MOVE)
            return vxfg_pkg::FLT_GP;
        if (mis && r.size != vxfg_pkg::SZ_128 && b[18] && r.psw[18] && r.current_privilege_level == 2'h3)
            return vxfg_pkg::FLT_AC;
        if (r.fp_unmasked) return e[10] ? vxfg_pkg::FLT_XF : vxfg_pkg::FLT_UD;
        return vxfg_pkg::FLT_NONE;
    endfunction

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one apb transfer; the request is held until pready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no cycle budget here: only the watchdog ends a wait that never finishes
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        rd2 = prdata2;
        err2 = pslverr2;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        if (a == vxfg_pkg::ADDR_BASE) sh_base = d & vxfg_pkg::BASE_WMASK;
        if (a == vxfg_pkg::ADDR_EXT) sh_ext = d & vxfg_pkg::EXT_WMASK;
        if (a == vxfg_pkg::ADDR_EXT && !d[vxfg_pkg::OSFS_BIT]) sh_ext2 = d & vxfg_pkg::EXT_WMASK;
        if (a == vxfg_pkg::ADDR_MASK) sh_mask = d[5:0];
    endtask

    task rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(nm, rd, exp);
    endtask

    task issue(input vxfg_pkg::vxfg_req_t r);
        @(posedge clock);
        cmd <= r;
        go <= 1'b1;
    endtask

    // let the pipeline empty so no event collides with the clearing read
    task stat_check;
        @(posedge clock);
        go <= 1'b0;
        repeat (4) @(posedge clock);
        chk("irq", {31'h0, irq}, {31'h0, |(exp_stat & sh_mask)});
        rreg(vxfg_pkg::ADDR_STAT, {26'h0, exp_stat}, "status");
        exp_stat = 6'h00;
        repeat (2) @(posedge clock);
        chk("irq_clear", {31'h0, irq}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////
    // verdict must follow each request by one cycle; sampled mid-cycle where it is settled
    always @(negedge clock) begin
        if (rst_n) begin
            chk("verdict_valid", {31'h0, verdict.valid}, {31'h0, pv});
            if (pv) begin
                chk("fault", {29'h0, verdict.fault}, {29'h0, pf});
                chk("commit", {31'h0, verdict.commit}, {31'h0, pf == vxfg_pkg::FLT_NONE});
                chk("default", {31'h0, verdict.default_result}, {31'h0, pf == vxfg_pkg::FLT_NONE && pm});
                chk("fault_lean", {29'h0, verdict2.fault}, {29'h0, pf2});
                if (pf != vxfg_pkg::FLT_NONE) exp_stat[pf - 3'h1] = 1'b1;
            end
            pv = req.valid;
            pf = exp_fault(req, sh_base, sh_ext);
            // in the lean build only line flush has its flag; every other op lacks one
            pf2 = (req.op == vxfg_pkg::OP_LINE_FLUSH) ? exp_fault(req, sh_base, sh_ext2) : vxfg_pkg::FLT_UD;
            pm = req.fp_masked;
        end
    end

    initial begin
        #400000;
        failures++;
        end_sim;
    end

    initial begin
        logic [31:0] rd;
        logic err;
        vxfg_pkg::vxfg_req_t r;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rreg(vxfg_pkg::ADDR_BASE, vxfg_pkg::BASE_RST, "base_rst");
        rreg(vxfg_pkg::ADDR_EXT, vxfg_pkg::EXT_RST, "ext_rst");
        rreg(vxfg_pkg::ADDR_STAT, 32'h0, "stat_rst");
        rreg(vxfg_pkg::ADDR_MASK, 32'h0, "mask_rst");
        apb(1'b0, vxfg_pkg::ADDR_ID, 32'h0, rd, err);
        chk("id_flags", rd & 32'h0708_0000, 32'h0708_0000);
        chk("id_flags_lean", rd2 & 32'h0708_0000, 32'h0208_0000);
        wreg(vxfg_pkg::ADDR_ID, ~rd);
        rreg(vxfg_pkg::ADDR_ID, rd, "id_read_only");
        apb(1'b0, 8'h14, 32'h0, rd, err);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        // corner: fallback set with both enables clear, every op back to back
        wreg(vxfg_pkg::ADDR_BASE, 32'h0000_000c);
        wreg(vxfg_pkg::ADDR_EXT, 32'h0);
        wreg(vxfg_pkg::ADDR_MASK, 32'h3f);
        for (int i = 0; i < 7; i++) begin
            r = '0;
            r.valid = 1'b1;
            r.op = vxfg_pkg::vxfg_op_t'(i);
            r.fp_unmasked = 1'b1;
            issue(r);
        end
        stat_check();
        wreg(vxfg_pkg::ADDR_BASE, 32'h0);
        wreg(vxfg_pkg::ADDR_EXT, 32'h600);
        chk("cfg_refused", {31'h0, err2}, 32'h1);
        apb(1'b0, vxfg_pkg::ADDR_STAT, 32'h0, rd, err);
        chk("cfg_event", rd2 & 32'h0000_0020, 32'h0000_0020);
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            // fallback and task switch set one time in four, so most requests reach the later checks
            wreg(vxfg_pkg::ADDR_BASE, (seed & 32'h0004_0022) | {28'h0, seed[10] & seed[11], seed[12] & seed[13], 2'h0});
            wreg(vxfg_pkg::ADDR_EXT, {21'h0, seed[20], seed[19] | seed[21] | seed[22], 9'h0});
            wreg(vxfg_pkg::ADDR_MASK, {26'h0, seed[29:24]});
            for (int j = 0; j < 16; j++) begin
                seed = lfsr(seed);
                r = '0;
                r.valid = 1'b1;
                r.op = vxfg_pkg::vxfg_op_t'((seed[2:0] == 3'h7) ? 3'h0 : seed[2:0]);
                r.mem_ref = seed[3] | seed[4];
                r.stack_seg = seed[5];
                r.size = vxfg_pkg::vxfg_size_t'(seed[7:6]);
                r.addr_lo = seed[12] ? seed[11:8] : 4'h0;
                r.current_privilege_level = seed[14:13] | {2{seed[15]}};
                r.psw = {seed[15:0], seed[31:16]};
                r.fp_unmasked = seed[17] & seed[18];
                r.fp_masked = seed[19];
                issue(r);
            end
            stat_check();
        end
        end_sim;
    end
endmodule // tb
